// [src/pfs_pkg.sv]
// constants and types shared by the port function select block
package pfs_pkg;

   // register byte offsets inside the block window
   localparam logic [7:0] OFF_PA_FUNC_LOW    = 8'h00;
   localparam logic [7:0] OFF_PB_DIRECTION   = 8'h04;
   localparam logic [7:0] OFF_PB_FUNC_HIGH   = 8'h08;
   localparam logic [7:0] OFF_PB_FUNC_LOW    = 8'h0C;
   localparam logic [7:0] OFF_PC_DIRECTION   = 8'h10;
   localparam logic [7:0] OFF_PC_FUNCTION    = 8'h14;

   // values after power-on reset
   localparam logic [15:0] RST_REG           = 16'h0000;
   localparam logic [9:0]  RST_PB_OE_N       = 10'h3FF;
   localparam logic [15:0] RST_PC_OE_N       = 16'hFFFF;

   // writable bit masks; all other bits are reserved and read zero
   localparam logic [15:0] WMASK_PA_FUNC_LOW = 16'h0075;
   localparam logic [15:0] WMASK_PB_DIR      = 16'h03FF;
   localparam logic [15:0] WMASK_PB_DIR_RED  = 16'h03FC;
   localparam logic [15:0] WMASK_PB_FHIGH    = 16'h000F;
   localparam logic [15:0] WMASK_PB_FLOW     = 16'hFFF5;
   localparam logic [15:0] WMASK_PB_FLOW_RED = 16'hFFF0;
   localparam logic [15:0] WMASK_PC          = 16'hFFFF;

   // port A low function field positions
   localparam int PA3_SEL_POS   = 6;
   localparam int PA2_SEL_POS   = 4;
   localparam int PA1_SEL_POS   = 2;
   localparam int PA0_SEL_POS   = 0;

   // port A pin 2 codes
   localparam logic [1:0] PA2_CODE_DMA = 2'b10;

   // port B selector codes
   localparam logic [1:0] PB_CODE_GPIO = 2'b00;
   localparam logic [1:0] PB_CODE_01   = 2'b01;
   localparam logic [1:0] PB_CODE_10   = 2'b10;
   localparam logic [1:0] PB_CODE_11   = 2'b11;

   // port B pin carrying the wait-request input
   localparam int PB_WAIT_PIN   = 8;
   localparam int PB_HIGH_FIRST = 8;

   // AHB-Lite encodings
   localparam logic       HRESP_OKAY = 1'b0;

   // resolved function of a port B pin
   typedef enum logic [1:0] {
      FN_GPIO,
      FN_IRQ,
      FN_ADDR,
      FN_BUS
   } pfs_pin_fn_t;

endpackage

// [src/pfs_top.sv]
// port B/C and port A low pin function select with AHB-Lite registers
//
// Functional notes
// - port A pin 3 selector: 0 general I/O, 1 serial channel 1 receive.
// - port A pin 2 code: I/O, serial0 clock, DMA request, interrupt 0.
// - port A pin 1 selector: 0 general I/O, 1 serial channel 0 transmit.
// - port A pin 0 selector: 0 general I/O, 1 serial channel 0 receive.
// - reserved register bits read zero; software writes zero there.
// - port B direction bit 1 makes pin output, 0 makes input.
// - port B direction matters only while pin is general I/O.
// - both port B function registers clear to zero at power-on reset only.
// - port B and C direction registers clear at power-on reset only.
// - reduced variant: port B direction bits 1,0 read zero, no effect.
// - reduced variant: port B low function bits 2,0 read zero, no effect.
// - port B pin 9: I/O, interrupt 7, address 21; 11 reserved.
// - port B pin 8: I/O, interrupt 6, address 20, wait request.
// - port B pin 7: I/O or address 19; other codes reserved.
// - port B pin 6: I/O or address 18; other codes reserved.
// - port B pin 5: I/O, interrupt 3, read/write direction output.
// - port B pin 4: I/O, interrupt 2, upper column strobe.
// - port B pin 3: I/O, interrupt 1, lower column strobe.
// - port B pin 2: I/O, interrupt 0, row address strobe.
// - port B pin 1: I/O or address 17; ROM-off forces address.
// - port B pin 0: I/O or address 16; ROM-off forces address.
// - single-chip mode turns port B bus and address picks into I/O.
// - port C direction bit sets pin output only while general I/O.
// - port C function register, one bit per pin, clears to zero.
// - port C bit n: I/O or address n; mode overrides apply.
`timescale 1ns/1ps

module pfs_top #(
   parameter bit REDUCED_PIN = 1'b0
) (
   // clock, reset, enable
   input  logic        hclk,
   input  logic        hresetn,
   input  logic        ce,
   // AHB-Lite slave
   input  logic        hsel,
   input  logic [31:0] haddr,
   input  logic [1:0]  htrans,
   input  logic        hwrite,
   input  logic [2:0]  hsize,
   input  logic [31:0] hwdata,
   input  logic        hready,
   output logic        hreadyout,
   output logic        hresp,
   output logic [31:0] hrdata,
   // operating mode
   input  logic        single_chip,
   input  logic        rom_disabled,
   // resolved pin functions and output enables
   output logic [7:0]  pa_fn,
   output logic [19:0] pb_fn,
   output logic [9:0]  pb_oe_n,
   output logic [15:0] pc_fn,
   output logic [15:0] pc_oe_n
);

   localparam logic [15:0] PB_DIR_WMASK =
      REDUCED_PIN ? pfs_pkg::WMASK_PB_DIR_RED : pfs_pkg::WMASK_PB_DIR;
   localparam logic [15:0] PB_FLOW_WMASK =
      REDUCED_PIN ? pfs_pkg::WMASK_PB_FLOW_RED : pfs_pkg::WMASK_PB_FLOW;

   // raw port B decode, before any mode override
   function automatic pfs_pkg::pfs_pin_fn_t pb_decode(
      input int         pin,
      input logic [1:0] code
   );
      pfs_pkg::pfs_pin_fn_t fn;
      fn = pfs_pkg::FN_GPIO;
      if (pin >= pfs_pkg::PB_HIGH_FIRST) begin
         case (code)
            pfs_pkg::PB_CODE_01: fn = pfs_pkg::FN_IRQ;
            pfs_pkg::PB_CODE_10: fn = pfs_pkg::FN_ADDR;
            pfs_pkg::PB_CODE_11: fn = (pin == pfs_pkg::PB_WAIT_PIN) ?
                                      pfs_pkg::FN_BUS : pfs_pkg::FN_GPIO;
            default:             fn = pfs_pkg::FN_GPIO;
         endcase
      end else if (pin >= 6) begin
         // reserved codes fall back to general I/O
         if (code == pfs_pkg::PB_CODE_10) begin
            fn = pfs_pkg::FN_ADDR;
         end
      end else if (pin >= 2) begin
         case (code)
            pfs_pkg::PB_CODE_01: fn = pfs_pkg::FN_IRQ;
            pfs_pkg::PB_CODE_11: fn = pfs_pkg::FN_BUS;
            default:             fn = pfs_pkg::FN_GPIO;
         endcase
      end else begin
         // pins 1 and 0 have one selector bit; the upper bit is reserved
         if (code[0]) begin
            fn = pfs_pkg::FN_ADDR;
         end
      end
      return fn;
   endfunction

   // register state
   logic [15:0] pa_func_low_q, pa_func_low_d;
   logic [15:0] pb_dir_q,      pb_dir_d;
   logic [15:0] pb_fh_q,       pb_fh_d;
   logic [15:0] pb_fl_q,       pb_fl_d;
   logic [15:0] pc_dir_q,      pc_dir_d;
   logic [15:0] pc_func_q,     pc_func_d;

   // bus state
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic [31:0] hrdata_q;
   logic        hreadyout_q;
   logic        hresp_q;

   // output flops and their next values
   logic [7:0]  pa_fn_q,   pa_fn_d;
   logic [19:0] pb_fn_q,   pb_fn_d;
   logic [9:0]  pb_oe_n_q, pb_oe_n_d;
   logic [15:0] pc_fn_q,   pc_fn_d;
   logic [15:0] pc_oe_n_q, pc_oe_n_d;

   // address phase decode
   wire         addr_phase = hsel & hready & htrans[1];
   wire  [7:0]  bus_off    = haddr[7:0];

   // write enables in the data phase
   wire we_pa_fl  = wr_pend_q & (wr_addr_q == pfs_pkg::OFF_PA_FUNC_LOW);
   wire we_pb_dir = wr_pend_q & (wr_addr_q == pfs_pkg::OFF_PB_DIRECTION);
   wire we_pb_fh  = wr_pend_q & (wr_addr_q == pfs_pkg::OFF_PB_FUNC_HIGH);
   wire we_pb_fl  = wr_pend_q & (wr_addr_q == pfs_pkg::OFF_PB_FUNC_LOW);
   wire we_pc_dir = wr_pend_q & (wr_addr_q == pfs_pkg::OFF_PC_DIRECTION);
   wire we_pc_fn  = wr_pend_q & (wr_addr_q == pfs_pkg::OFF_PC_FUNCTION);

   // masked next values; reserved bits can never be stored
   wire [15:0] wdata = hwdata[15:0];
   assign pa_func_low_d = we_pa_fl  ? (wdata & pfs_pkg::WMASK_PA_FUNC_LOW) :
                                      pa_func_low_q;
   assign pb_dir_d      = we_pb_dir ? (wdata & PB_DIR_WMASK)  : pb_dir_q;
   assign pb_fh_d       = we_pb_fh  ? (wdata & pfs_pkg::WMASK_PB_FHIGH) :
                                      pb_fh_q;
   assign pb_fl_d       = we_pb_fl  ? (wdata & PB_FLOW_WMASK) : pb_fl_q;
   assign pc_dir_d      = we_pc_dir ? (wdata & pfs_pkg::WMASK_PC) : pc_dir_q;
   assign pc_func_d     = we_pc_fn  ? (wdata & pfs_pkg::WMASK_PC) : pc_func_q;

   // read mux looks at next values so a read right after a write sees it
   wire [15:0] rd_word =
      (bus_off == pfs_pkg::OFF_PA_FUNC_LOW)  ? pa_func_low_d :
      (bus_off == pfs_pkg::OFF_PB_DIRECTION) ? pb_dir_d      :
      (bus_off == pfs_pkg::OFF_PB_FUNC_HIGH) ? pb_fh_d       :
      (bus_off == pfs_pkg::OFF_PB_FUNC_LOW)  ? pb_fl_d       :
      (bus_off == pfs_pkg::OFF_PC_DIRECTION) ? pc_dir_d      :
      (bus_off == pfs_pkg::OFF_PC_FUNCTION)  ? pc_func_d     :
                                               16'h0000;

   // port A pins 3..0
   wire [1:0] pa2_code = pa_func_low_q[pfs_pkg::PA2_SEL_POS +: 2];
   wire [1:0] pa2_res  = (single_chip && pa2_code == pfs_pkg::PA2_CODE_DMA) ?
                         2'b00 : pa2_code;
   assign pa_fn_d = {1'b0, pa_func_low_q[pfs_pkg::PA3_SEL_POS],
                     pa2_res,
                     1'b0, pa_func_low_q[pfs_pkg::PA1_SEL_POS],
                     1'b0, pa_func_low_q[pfs_pkg::PA0_SEL_POS]};

   // port B pins 9..0
   genvar gb;
   generate
      for (gb = 0; gb < 10; gb++) begin : g_pb
         localparam int FPOS = (gb >= pfs_pkg::PB_HIGH_FIRST) ?
                               2 * (gb - pfs_pkg::PB_HIGH_FIRST) : 2 * gb;
         localparam bit ABSENT = REDUCED_PIN && (gb < 2);
         wire [1:0] code = (gb >= pfs_pkg::PB_HIGH_FIRST) ?
                           pb_fh_q[FPOS +: 2] : pb_fl_q[FPOS +: 2];
         pfs_pkg::pfs_pin_fn_t raw_fn;
         pfs_pkg::pfs_pin_fn_t res_fn;
         assign raw_fn = pb_decode(gb, code);
         // mode override first, register code second
         assign res_fn =
            ABSENT ? pfs_pkg::FN_GPIO :
            (single_chip && (raw_fn == pfs_pkg::FN_ADDR ||
                             raw_fn == pfs_pkg::FN_BUS)) ? pfs_pkg::FN_GPIO :
            (rom_disabled && !single_chip && gb < 2) ? pfs_pkg::FN_ADDR :
            raw_fn;
         assign pb_fn_d[2*gb +: 2] = res_fn;
         // wait request is the only bus function that is an input
         assign pb_oe_n_d[gb] =
            ABSENT                       ? 1'b1 :
            (res_fn == pfs_pkg::FN_GPIO) ? ~pb_dir_q[gb] :
            (res_fn == pfs_pkg::FN_IRQ)  ? 1'b1 :
            (res_fn == pfs_pkg::FN_ADDR) ? 1'b0 :
            (gb == pfs_pkg::PB_WAIT_PIN);
      end
   endgenerate

   // port C pins 15..0; no pins at all in the reduced variant
   genvar gc;
   generate
      for (gc = 0; gc < 16; gc++) begin : g_pc
         wire is_addr = !REDUCED_PIN && !single_chip &&
                        (rom_disabled || pc_func_q[gc]);
         assign pc_fn_d[gc]   = is_addr;
         assign pc_oe_n_d[gc] = REDUCED_PIN ? 1'b1 :
                                is_addr ? 1'b0 : ~pc_dir_q[gc];
      end
   endgenerate

   // registers: only the power-on reset clears them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pa_func_low_q <= pfs_pkg::RST_REG;
         pb_dir_q      <= pfs_pkg::RST_REG;
         pb_fh_q       <= pfs_pkg::RST_REG;
         pb_fl_q       <= pfs_pkg::RST_REG;
         pc_dir_q      <= pfs_pkg::RST_REG;
         pc_func_q     <= pfs_pkg::RST_REG;
      end else if (ce) begin
         pa_func_low_q <= pa_func_low_d;
         pb_dir_q      <= pb_dir_d;
         pb_fh_q       <= pb_fh_d;
         pb_fl_q       <= pb_fl_d;
         pc_dir_q      <= pc_dir_d;
         pc_func_q     <= pc_func_d;
      end
   end

   // bus slave: zero wait states, read data fetched in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q   <= 1'b0;
         wr_addr_q   <= 8'h00;
         hrdata_q    <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q     <= pfs_pkg::HRESP_OKAY;
      end else if (ce) begin
         wr_pend_q   <= addr_phase & hwrite;
         wr_addr_q   <= bus_off;
         hreadyout_q <= 1'b1;
         hresp_q     <= pfs_pkg::HRESP_OKAY;
         if (addr_phase && !hwrite) begin
            hrdata_q <= {16'h0000, rd_word};
         end
      end
   end

   // outputs are registered so pins never glitch on a mode change
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pa_fn_q   <= 8'h00;
         pb_fn_q   <= 20'h0_0000;
         pb_oe_n_q <= pfs_pkg::RST_PB_OE_N;
         pc_fn_q   <= 16'h0000;
         pc_oe_n_q <= pfs_pkg::RST_PC_OE_N;
      end else if (ce) begin
         pa_fn_q   <= pa_fn_d;
         pb_fn_q   <= pb_fn_d;
         pb_oe_n_q <= pb_oe_n_d;
         pc_fn_q   <= pc_fn_d;
         pc_oe_n_q <= pc_oe_n_d;
      end
   end

   assign hreadyout = hreadyout_q;
   assign hresp     = hresp_q;
   assign hrdata    = hrdata_q;
   assign pa_fn     = pa_fn_q;
   assign pb_fn     = pb_fn_q;
   assign pb_oe_n   = pb_oe_n_q;
   assign pc_fn     = pc_fn_q;
   assign pc_oe_n   = pc_oe_n_q;

   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_wr_pb_fh;
      ce && addr_phase && hwrite && bus_off == pfs_pkg::OFF_PB_FUNC_HIGH ##1 ce;
   endsequence

   sequence s_rd_pb_fh;
      ce && addr_phase && !hwrite && bus_off == pfs_pkg::OFF_PB_FUNC_HIGH;
   endsequence

   property p_pb_fh_write;
      s_wr_pb_fh |=> pb_fh_q == ($past(hwdata[15:0]) & pfs_pkg::WMASK_PB_FHIGH);
   endproperty
   a_pb_fh_write: assert property (p_pb_fh_write)
      else $error("port B high function write not stored as masked");

   property p_reserved_read;
      s_rd_pb_fh |=> hrdata[31:4] == 28'h000_0000;
   endproperty
   a_reserved_read: assert property (p_reserved_read)
      else $error("reserved bits read nonzero");

   property p_pa2_dma_single;
      (ce && single_chip && pa2_code == pfs_pkg::PA2_CODE_DMA) |=> pa_fn[5:4] == 2'b00;
   endproperty
   a_pa2_dma_single: assert property (p_pa2_dma_single)
      else $error("port A pin 2 DMA not overridden in single-chip mode");

   property p_pa1_follow;
      ce |=> pa_fn[3:2] == {1'b0, $past(pa_func_low_q[pfs_pkg::PA1_SEL_POS])};
   endproperty
   a_pa1_follow: assert property (p_pa1_follow)
      else $error("port A pin 1 function does not follow its selector");

   property p_pb9_gpio_dir;
      (ce && pb_fh_q[3:2] == pfs_pkg::PB_CODE_GPIO) |=> pb_oe_n[9] == !$past(pb_dir_q[9]);
   endproperty
   a_pb9_gpio_dir: assert property (p_pb9_gpio_dir)
      else $error("port B pin 9 direction wrong in general I/O");

   property p_pb9_irq_input;
      (ce && pb_fh_q[3:2] == pfs_pkg::PB_CODE_01) |=> pb_oe_n[9] && pb_fn[19:18] == 2'b01;
   endproperty
   a_pb9_irq_input: assert property (p_pb9_irq_input)
      else $error("port B pin 9 interrupt input driven");

   property p_pb8_single;
      (ce && single_chip && pb_fh_q[1]) |=> pb_fn[17:16] == 2'b00;
   endproperty
   a_pb8_single: assert property (p_pb8_single)
      else $error("port B pin 8 bus code not overridden in single-chip mode");

   property p_pb1_rom_off;
      (ce && !REDUCED_PIN && !single_chip && rom_disabled) |=>
         pb_fn[3:2] == 2'b10 && !pb_oe_n[1];
   endproperty
   a_pb1_rom_off: assert property (p_pb1_rom_off)
      else $error("port B pin 1 not forced to address with ROM off");

   property p_pc15_addr;
      (ce && !REDUCED_PIN && !single_chip && pc_func_q[15]) |=> pc_fn[15] && !pc_oe_n[15];
   endproperty
   a_pc15_addr: assert property (p_pc15_addr)
      else $error("port C pin 15 address output missing");

   property p_pc_dir_hold;
      (ce && !wr_pend_q) |=> $stable(pc_dir_q) && $stable(pb_dir_q);
   endproperty
   a_pc_dir_hold: assert property (p_pc_dir_hold)
      else $error("direction register changed without a write");

   property p_reduced_pb_dir;
      ce |=> (!REDUCED_PIN || pb_dir_q[1:0] == 2'b00);
   endproperty
   a_reduced_pb_dir: assert property (p_reduced_pb_dir)
      else $error("absent port B direction bits not zero");

endmodule

// [tb/pfs_mode_pins.sv]
// mode strap model standing in for the device's mode pins
`timescale 1ns/1ps

module pfs_mode_pins (
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // requested mode: 0 rom on, 1 rom off, 2 single chip
   input  wire logic [1:0] mode_req,
   // mode lines seen by the device
   output logic            single_chip,
   output logic            rom_disabled
);
   // straps settle on an edge; the two modes never show at once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         single_chip  <= 1'b0;
         rom_disabled <= 1'b0;
      end else begin
         single_chip  <= mode_req[1];
         rom_disabled <= mode_req[0] & ~mode_req[1];
      end
   end
endmodule

// [tb/pfs_top_tb.sv]
// self-checking bench for the port function select block
`timescale 1ns/1ps

module pfs_top_tb;
   localparam logic [15:0] MSK [6] = '{16'h0075, 16'h03FF, 16'h000F, 16'hFFF5, 16'hFFFF, 16'hFFFF};
   localparam logic [15:0] MSKR [4] = '{16'h0075, 16'h03FC, 16'h000F, 16'hFFF0};
   logic        hclk;
   logic        hresetn;
   logic        ce;
   logic        hsel;
   logic        hsel_red;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [31:0] hrdata_red;
   logic [1:0]  mode_req;
   logic        single_chip;
   logic        rom_disabled;
   logic [69:0] outs;
   logic [69:0] outs_red;
   logic [15:0] m [6];
   logic [15:0] mr [6];
   int          errors;
   int          compares;

   // software never touches port C of the reduced part
   assign hsel_red = hsel & (haddr[7:0] < 8'h10);

   pfs_mode_pins straps (.hclk(hclk), .hresetn(hresetn), .mode_req(mode_req),
      .single_chip(single_chip), .rom_disabled(rom_disabled));

   pfs_top #(.REDUCED_PIN(1'b0)) uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .single_chip(single_chip), .rom_disabled(rom_disabled), .pa_fn(outs[69:62]),
      .pb_fn(outs[61:42]), .pb_oe_n(outs[41:32]), .pc_fn(outs[31:16]), .pc_oe_n(outs[15:0]));

   pfs_top #(.REDUCED_PIN(1'b1)) uut_red (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .hsel(hsel_red), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(hrdata_red),
      .single_chip(single_chip), .rom_disabled(rom_disabled), .pa_fn(outs_red[69:62]),
      .pb_fn(outs_red[61:42]), .pb_oe_n(outs_red[41:32]), .pc_fn(outs_red[31:16]),
      .pc_oe_n(outs_red[15:0]));

   // layout: pa_fn, pb_fn, pb_oe_n, pc_fn, pc_oe_n
   function automatic logic [69:0] expect_out(input logic [15:0] r [6], input bit red,
                                               input bit sc, input bit rd);
      int          fn;
      int          c;
      logic [69:0] e;
      e = '0;
      c = int'(r[0][5:4]);
      if (sc && c == 2) c = 0;
      e[69:62] = {1'b0, r[0][6], 2'(c), 1'b0, r[0][2], 1'b0, r[0][0]};
      for (int p = 0; p < 10; p++) begin
         c = int'({r[2], r[3]} >> (2 * p)) & 3;
         case (p)
            9: fn = (c == 1) ? 1 : (c == 2) ? 2 : 0;
            8: fn = c;
            7, 6: fn = (c == 2) ? 2 : 0;
            1, 0: fn = red ? 0 : (rd || (c & 1)) ? 2 : 0;
            default: fn = (c == 1) ? 1 : (c == 3) ? 3 : 0;
         endcase
         if (sc && fn >= 2) fn = 0;
         e[42 + 2 * p +: 2] = 2'(fn);
         e[32 + p] = (fn == 0) ? ~r[1][p] : (fn == 1 || (fn == 3 && p == 8));
      end
      for (int n = 0; n < 16; n++) begin
         fn = (red || sc) ? 0 : rd ? 1 : int'(r[5][n]);
         e[16 + n] = fn[0];
         e[n] = fn[0] ? 1'b0 : ~r[4][n];
      end
      return e;
   endfunction

   task automatic chk(input logic [69:0] got, input logic [69:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one whole-word transfer; hready is sampled at each edge before moving on
   task automatic bus(input bit wr, input int idx, input logic [31:0] d,
                      output logic [31:0] q, output logic [31:0] qr);
      hsel <= 1'b1;
      haddr <= 32'(4 * idx);
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
      qr = hrdata_red;
      chk(70'(hresp), 70'(pfs_pkg::HRESP_OKAY), "response");
   endtask

   task automatic wr_reg(input int idx, input logic [15:0] d);
      logic [31:0] q;
      logic [31:0] qr;
      bus(1'b1, idx, {16'hA5A5, d}, q, qr);
      if (idx < 6) m[idx] = d & MSK[idx];
      if (idx < 4) mr[idx] = d & MSKR[idx];
   endtask

   task automatic rd_reg(input int idx);
      logic [31:0] q;
      logic [31:0] qr;
      bus(1'b0, idx, 32'h0000_0000, q, qr);
      chk(70'(q), (idx < 6) ? 70'(m[idx]) : 70'h0, "read");
      if (idx < 4) chk(70'(qr), 70'(mr[idx]), "read reduced");
   endtask

   // two edges for the strap and the output flops, one to sample
   task automatic check_pins();
      repeat (3) @(posedge hclk);
      // zero wait states: ready must stand high even between transfers
      chk(70'(hreadyout), 70'(1'b1), "ready idle");
      chk(outs, expect_out(m, 1'b0, mode_req[1], mode_req == 2'b01), "pins");
      chk(outs_red, expect_out(mr, 1'b1, mode_req[1], mode_req == 2'b01), "pins red");
   endtask

   task automatic wrap_up();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   initial begin
      repeat (40000) @(posedge hclk);
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
   end

   initial begin
      errors = 0;
      compares = 0;
      hresetn = 1'b0;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = '0;
      mode_req = 2'b00;
      for (int i = 0; i < 6; i++) begin
         m[i] = '0;
         mr[i] = '0;
      end
      void'($urandom(92036));
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      check_pins();
      for (int i = 0; i < 7; i++) rd_reg(i);
      for (int i = 0; i < 7; i++) wr_reg(i, 16'hFFFF);
      for (int i = 0; i < 7; i++) rd_reg(i);
      check_pins();
      for (int k = 0; k < 150; k++) begin
         mode_req <= 2'($urandom_range(0, 2));
         for (int i = 0; i < 6; i++) wr_reg(i, 16'($urandom()) & MSK[i]);
         check_pins();
         rd_reg($urandom_range(0, 6));
      end
      // frozen clock enable must hold the old pin picture
      mode_req <= 2'b01;
      check_pins();
      ce <= 1'b0;
      mode_req <= 2'b10;
      repeat (4) @(posedge hclk);
      chk(outs, expect_out(m, 1'b0, 1'b0, 1'b1), "frozen");
      chk(outs_red, expect_out(mr, 1'b1, 1'b0, 1'b1), "frozen red");
      ce <= 1'b1;
      check_pins();
      // a second power-on reset in mid-run clears every register
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         m[i] = '0;
         mr[i] = '0;
      end
      check_pins();
      for (int i = 0; i < 6; i++) rd_reg(i);
      wrap_up();
   end
endmodule
